// file: design/prot_pkg.sv
// Package for the output protection controller: register map, field positions, reset values, counts, types.
// Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
package prot_pkg;
    localparam int n_out = 14;
    localparam int n_sa = 10;
    localparam int n_ar = 9;
    localparam logic [7:0] a_ctrl = 8'h00;
    localparam logic [7:0] a_supst = 8'h04;
    localparam logic [7:0] a_ocst = 8'h08;
    localparam logic [7:0] a_olst = 8'h0c;
    localparam logic [7:0] a_arcfg = 8'h10;
    localparam logic [7:0] a_arst = 8'h14;
    localparam logic [7:0] a_src0 = 8'h18;
    localparam logic [7:0] a_src1 = 8'h1c;
    localparam logic [7:0] a_src2 = 8'h20;
    localparam logic [7:0] a_tim = 8'h24;
    localparam logic [7:0] a_cfg3f = 8'h3f;
    localparam logic [7:0] a_cfg = 8'hfc;
    localparam int b_ov_sd = 0;
    localparam int b_uv_sd = 1;
    localparam int b_lock = 2;
    localparam int b_standby = 3;
    localparam int b_pump_live = 0;
    localparam logic [31:0] ctrl_rst = 32'h0000_0003;
    localparam logic [3:0] src_off = 4'h0;
    localparam logic [3:0] src_on = 4'h1;
    localparam logic [3:0] src_t1 = 4'h2;
    localparam logic [3:0] src_t2 = 4'h3;
    localparam logic [3:0] src_pwm1 = 4'h4;
    localparam logic [3:0] src_direction_input_one = 4'he;
    localparam logic [3:0] src_direction_input_two = 4'hf;
    localparam int clk_mhz = 100;
    localparam int pump_low_filter_us = 64;
    localparam logic [15:0] pump_low_filter_cyc = 16'(pump_low_filter_us * clk_mhz);
    localparam logic [15:0] hs_rec_rst = 16'h0400;
    localparam logic [15:0] hb_rec_rst = 16'h0200;
    localparam logic [15:0] ar_time_rst = 16'h1000;

    typedef enum logic [3:0] {
        th_normal = 4'b0001,
        th_warn = 4'b0010,
        th_stage_one = 4'b0100,
        th_stage_two = 4'b1000
    } thermal_t;

    typedef struct packed {
        logic regsup_ov;
        logic regsup_uv;
        logic bat_ov;
        logic bat_uv;
        logic temp_warn;
        logic temp_one;
        logic temp_two;
        logic pump_low;
        logic gnd_lost;
        logic fail_safe;
        logic cluster_rise;
        logic [n_out-1:0] overcurrent;
        logic [n_out-1:0] open_load;
    } sense_t;

    typedef struct packed {
        logic [n_out-1:0] out_on;
        logic regsup_hs_on;
        logic contact_on;
        logic lin_hiz;
        logic pump_en;
        logic gate_rl;
        logic ec_off;
    } drive_t;
endpackage : prot_pkg

// file: design/output_protection_control.sv
// Output protection and mode control for a door-actuator driver, with AXI4-Lite register access.
// Analog comparator results arrive asynchronously and are synchronized here; timers and PWM come in as levels.
`timescale 1ns/1ps
module output_protection_control (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire prot_pkg::sense_t sense,
    input wire logic bat_power_ok,
    input wire logic regsup_power_ok,
    input wire logic timer_one,
    input wire logic timer_two,
    input wire logic timer_one_restart,
    input wire logic timer_two_restart,
    input wire logic [9:0] pwm_gen,
    input wire logic direction_input_one,
    input wire logic direction_input_two,
    input wire logic [prot_pkg::n_out-1:0] out_request,
    output prot_pkg::drive_t drive
);
    localparam int sw = $bits(prot_pkg::sense_t);

    typedef struct packed {
        logic [sw-1:0] s1;
        logic [sw-1:0] s2;
        logic [sw-1:0] s3;
        logic [sw-1:0] sv;
        logic [2:0] pok1;
        logic [2:0] pok2;
        logic aw_got;
        logic w_got;
        logic [7:0] awa;
        logic [31:0] wd;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] ctrl;
        logic pump_low_live_select;
        logic [prot_pkg::n_ar-1:0] auto_recovery_enable;
        logic [prot_pkg::n_ar-1:0] thermal_expiry_enable;
        logic [prot_pkg::n_sa*4-1:0] output_source_select;
        logic [15:0] highside_recovery_frequency;
        logic [15:0] halfbridge_recovery_frequency;
        logic [15:0] auto_recovery_time;
        logic [15:0] pump_low_filter_time;
        logic regsup_overvolt_flag;
        logic regsup_undervolt_flag;
        logic pump_low_flag;
        logic cluster_overtemp_flag;
        logic gnd_lock;
        logic [15:0] pump_cnt;
        logic [prot_pkg::n_out-1:0] oc_flag;
        logic [prot_pkg::n_out-1:0] ol_flag;
        logic [prot_pkg::n_ar-1:0] auto_recovery_alert;
        logic [prot_pkg::n_ar-1:0] thermal_expiry_flag;
        logic [prot_pkg::n_ar-1:0] ar_hold;
        logic [prot_pkg::n_ar-1:0][15:0] ar_cnt;
        logic [prot_pkg::n_ar-1:0][15:0] ar_age;
        logic [15:0] hs_div;
        logic [15:0] hb_div;
        logic [1:0] tphase;
        prot_pkg::thermal_t th;
        prot_pkg::thermal_t th_saved;
        prot_pkg::drive_t drv;
    } state_t;

    state_t q;
    state_t d;

    // Output k of the auto-recovery set maps onto driver index ar_map(k)
    function automatic int ar_map(input int k);
        ar_map = (k < 8) ? k : prot_pkg::n_out - 1;
    endfunction : ar_map

    always_comb begin
        prot_pkg::sense_t sn;
        prot_pkg::sense_t rise;
        logic wr;
        logic rd;
        logic [7:0] ra;
        logic standby;
        logic regsup_off;
        logic bat_off;
        logic global_off;
        logic [prot_pkg::n_out-1:0] req;
        logic [3:0] sel;
        logic src;
        logic hs_tick;
        logic hb_tick;
        logic tick;
        logic [31:0] rv;
        d = q;
        sn = q.sv;
        rv = 32'h0000_0000;
        // Three-stage synchronizer; a change counts once stages two and three agree
        d.s1 = sense;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.sv = (q.s2 == q.s3) ? q.s3 : q.sv;
        d.pok1 = {1'b0, bat_power_ok, regsup_power_ok};
        d.pok2 = q.pok1;
        sn = d.sv;
        rise = sn & ~q.sv;
        standby = q.ctrl[prot_pkg::b_standby];

        // Bus: write address and data in either order, response after both
        if (s_axi_awvalid && !q.aw_got) begin
            d.aw_got = 1'b1;
            d.awa = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && !q.w_got) begin
            d.w_got = 1'b1;
            d.wd = s_axi_wdata;
        end
        wr = q.aw_got && q.w_got && !q.bvalid;
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        rd = s_axi_arvalid && !q.rvalid;
        ra = s_axi_araddr[7:0];
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end

        // Regulated-supply flags: hardware set wins over read-and-clear
        if (rd && ra == prot_pkg::a_supst) begin
            d.regsup_overvolt_flag = 1'b0;
            d.regsup_undervolt_flag = 1'b0;
            d.pump_low_flag = 1'b0;
            d.cluster_overtemp_flag = 1'b0;
        end
        if (!q.ctrl[prot_pkg::b_lock]) begin
            if (!sn.regsup_ov) d.regsup_overvolt_flag = 1'b0;
            if (!sn.regsup_uv) d.regsup_undervolt_flag = 1'b0;
        end
        if (sn.regsup_ov) d.regsup_overvolt_flag = 1'b1;
        if (sn.regsup_uv) d.regsup_undervolt_flag = 1'b1;

        // Pump-low filter, latched or live
        if (sn.pump_low && q.drv.pump_en) begin
            if (q.pump_cnt != q.pump_low_filter_time) d.pump_cnt = q.pump_cnt + 16'h0001;
        end else begin
            d.pump_cnt = 16'h0000;
        end
        if (q.pump_low_live_select && !(sn.pump_low && q.pump_cnt == q.pump_low_filter_time)) begin
            d.pump_low_flag = 1'b0;
        end
        if (sn.pump_low && q.pump_cnt == q.pump_low_filter_time) d.pump_low_flag = 1'b1;

        // Thermal state machine with standby save and restore
        case (q.th)
            prot_pkg::th_normal: if (sn.temp_warn) d.th = prot_pkg::th_warn;
            prot_pkg::th_warn: begin
                if (sn.temp_one) d.th = prot_pkg::th_stage_one;
                else if (!sn.temp_warn) d.th = prot_pkg::th_normal;
            end
            prot_pkg::th_stage_one: begin
                if (sn.temp_two) d.th = prot_pkg::th_stage_two;
                else if (!q.cluster_overtemp_flag && !sn.temp_one) d.th = prot_pkg::th_normal;
            end
            prot_pkg::th_stage_two: if (!sn.temp_two) d.th = prot_pkg::th_stage_one;
            default: d.th = prot_pkg::th_normal;
        endcase
        if (rise.temp_one) d.cluster_overtemp_flag = 1'b1;

        // Ground loss lock until both supplies cycle
        if (sn.gnd_lost) d.gnd_lock = 1'b1;
        else if (!q.pok2[0] && !q.pok2[1]) d.gnd_lock = 1'b0;

        // Recovery tick generators, separate frequencies per driver group
        hs_tick = (q.hs_div == q.highside_recovery_frequency);
        hb_tick = (q.hb_div == q.halfbridge_recovery_frequency);
        d.hs_div = hs_tick ? 16'h0000 : q.hs_div + 16'h0001;
        d.hb_div = hb_tick ? 16'h0000 : q.hb_div + 16'h0001;

        // Overcurrent and open-load flags
        d.oc_flag = q.oc_flag | sn.overcurrent;
        d.ol_flag = q.ol_flag | sn.open_load;
        for (int k = 0; k < prot_pkg::n_ar; k++) begin
            tick = (k < 4) ? hb_tick : hs_tick;
            if (q.auto_recovery_enable[k]) begin
                if (sn.overcurrent[ar_map(k)]) begin
                    d.ar_hold[k] = 1'b1;
                    d.auto_recovery_alert[k] = 1'b1;
                end else if (tick) begin
                    d.ar_hold[k] = 1'b0;
                end
                if (q.ar_hold[k] && q.ar_age[k] != q.auto_recovery_time) d.ar_age[k] = q.ar_age[k] + 16'h0001;
                if (q.thermal_expiry_enable[k] && q.ar_age[k] == q.auto_recovery_time && sn.cluster_rise) begin
                    d.thermal_expiry_flag[k] = 1'b1;
                end
                d.oc_flag[ar_map(k)] = 1'b0;
            end else begin
                d.ar_hold[k] = 1'b0;
                d.ar_age[k] = 16'h0000;
            end
            d.ar_cnt[k] = 16'h0000;
        end

        // Read-and-clear status and register writes
        if (rd) begin
            case (ra)
                prot_pkg::a_ctrl: rv = q.ctrl;
                prot_pkg::a_supst: rv = {22'h000000, q.th, q.gnd_lock, q.cluster_overtemp_flag, q.pump_low_flag,
                    1'b0, q.regsup_undervolt_flag, q.regsup_overvolt_flag};
                prot_pkg::a_ocst: rv = {18'h00000, q.oc_flag};
                prot_pkg::a_olst: rv = {18'h00000, q.ol_flag};
                prot_pkg::a_arcfg: rv = {14'h0000, q.thermal_expiry_enable, q.auto_recovery_enable};
                prot_pkg::a_arst: rv = {14'h0000, q.thermal_expiry_flag, q.auto_recovery_alert};
                prot_pkg::a_src0: rv = q.output_source_select[31:0];
                prot_pkg::a_src1: rv = {24'h000000, q.output_source_select[39:32]};
                prot_pkg::a_src2: rv = {q.halfbridge_recovery_frequency, q.highside_recovery_frequency};
                prot_pkg::a_tim: rv = {q.pump_low_filter_time, q.auto_recovery_time};
                prot_pkg::a_cfg: rv = {31'h00000000, q.pump_low_live_select};
                default: rv = 32'h0000_0000;
            endcase
            case (ra)
                prot_pkg::a_ocst: d.oc_flag = sn.overcurrent;
                prot_pkg::a_olst: d.ol_flag = sn.open_load;
                prot_pkg::a_arst: begin
                    d.auto_recovery_alert = q.ar_hold;
                    d.thermal_expiry_flag = '0;
                end
                default: ;
            endcase
            d.rvalid = 1'b1;
            d.rdata = rv;
            d.rresp = (ra inside {prot_pkg::a_ctrl, prot_pkg::a_supst, prot_pkg::a_ocst, prot_pkg::a_olst,
                prot_pkg::a_arcfg, prot_pkg::a_arst, prot_pkg::a_src0, prot_pkg::a_src1, prot_pkg::a_src2,
                prot_pkg::a_tim, prot_pkg::a_cfg}) ? 2'b00 : 2'b10;
        end
        if (wr) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = 2'b00;
            case (q.awa)
                prot_pkg::a_ctrl: d.ctrl = {28'h0000000, q.wd[3:0]};
                prot_pkg::a_arcfg: begin
                    d.auto_recovery_enable = q.wd[8:0];
                    d.thermal_expiry_enable = q.wd[17:9];
                end
                prot_pkg::a_src0: d.output_source_select[31:0] = q.wd;
                prot_pkg::a_src1: d.output_source_select[39:32] = q.wd[7:0];
                prot_pkg::a_src2: begin
                    d.highside_recovery_frequency = q.wd[15:0];
                    d.halfbridge_recovery_frequency = q.wd[31:16];
                end
                prot_pkg::a_tim: begin
                    d.auto_recovery_time = q.wd[15:0];
                    d.pump_low_filter_time = q.wd[31:16];
                end
                prot_pkg::a_cfg: d.pump_low_live_select = q.wd[prot_pkg::b_pump_live];
                default: d.bresp = 2'b10;
            endcase
        end

        // Standby edges are seen only after the control write above has been applied
        if (!q.ctrl[prot_pkg::b_standby] && d.ctrl[prot_pkg::b_standby]) d.th_saved = q.th;
        if (q.ctrl[prot_pkg::b_standby] && !d.ctrl[prot_pkg::b_standby]) begin
            d.th = (q.th_saved == prot_pkg::th_stage_two) ? prot_pkg::th_stage_one : q.th_saved;
        end

        // Timer restart forces the ON phase
        d.tphase[0] = timer_one_restart ? 1'b1 : timer_one;
        d.tphase[1] = timer_two_restart ? 1'b1 : timer_two;

        // Output gating
        regsup_off = (q.regsup_overvolt_flag && (q.ctrl[prot_pkg::b_ov_sd] || sn.regsup_ov)
                      && q.ctrl[prot_pkg::b_ov_sd])
                  || (q.regsup_undervolt_flag && q.ctrl[prot_pkg::b_uv_sd]);
        bat_off = sn.bat_ov || sn.bat_uv;
        global_off = bat_off || regsup_off || sn.fail_safe || q.gnd_lock || q.pump_low_flag
                     || q.cluster_overtemp_flag || q.th == prot_pkg::th_stage_two;
        d.drv.pump_en = !standby && !sn.bat_ov && !q.cluster_overtemp_flag && q.th != prot_pkg::th_stage_one
                        && q.th != prot_pkg::th_stage_two;
        req = out_request;
        for (int k = 0; k < prot_pkg::n_sa; k++) begin
            sel = q.output_source_select[k*4 +: 4];
            case (sel)
                prot_pkg::src_off: src = 1'b0;
                prot_pkg::src_on: src = 1'b1;
                prot_pkg::src_t1: src = q.tphase[0];
                prot_pkg::src_t2: src = q.tphase[1];
                prot_pkg::src_direction_input_one: src = direction_input_one;
                prot_pkg::src_direction_input_two: src = direction_input_two;
                default: src = pwm_gen[sel - prot_pkg::src_pwm1];
            endcase
            req[4 + k] = src;
        end
        for (int i = 0; i < prot_pkg::n_out; i++) begin
            d.drv.out_on[i] = req[i] && !global_off && !q.oc_flag[i] && q.drv.pump_en;
        end
        for (int k = 0; k < prot_pkg::n_ar; k++) begin
            if (q.ar_hold[k] || q.thermal_expiry_flag[k]) d.drv.out_on[ar_map(k)] = 1'b0;
        end
        d.drv.regsup_hs_on = req[prot_pkg::n_out - 1] && !regsup_off && !sn.fail_safe && !q.gnd_lock;
        d.drv.contact_on = req[prot_pkg::n_out - 1] && !regsup_off && !q.gnd_lock
                           && !q.ar_hold[prot_pkg::n_ar - 1];
        d.drv.lin_hiz = sn.regsup_ov || sn.regsup_uv;
        d.drv.gate_rl = q.pump_low_flag;
        d.drv.ec_off = q.pump_low_flag;
        if (!aresetn) begin
            d = '0;
            d.ctrl = prot_pkg::ctrl_rst;
            d.th = prot_pkg::th_normal;
            d.th_saved = prot_pkg::th_normal;
            d.highside_recovery_frequency = prot_pkg::hs_rec_rst;
            d.halfbridge_recovery_frequency = prot_pkg::hb_rec_rst;
            d.auto_recovery_time = prot_pkg::ar_time_rst;
            d.pump_low_filter_time = prot_pkg::pump_low_filter_cyc;
            d.drv.lin_hiz = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        q <= d;
    end

    assign s_axi_awready = !q.aw_got;
    assign s_axi_wready = !q.w_got;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign drive = q.drv;
endmodule : output_protection_control

// file: testbench/prot_checker_assertions.sv
// Checker for output_protection_control: protection reactions seen at the ports.
// Assumes one clock; a comparator level held 16 cycles counts as a settled fault.
`timescale 1ns/1ps
module prot_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire prot_pkg::sense_t sense,
    input wire prot_pkg::drive_t drive
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Long enough to cover the input synchronizer and the output register
    sequence held(x);
        x [*8] ##1 x [*8];
    endsequence
    ov_lin_float_a: assert property (held(sense.regsup_ov) |-> drive.lin_hiz)
        else $error("lin not floated on regsup overvoltage");
    uv_lin_float_a: assert property (held(sense.regsup_uv) |-> drive.lin_hiz)
        else $error("lin not floated on regsup undervoltage");
    ground_loss_off_a: assert property (held(sense.gnd_lost) |-> drive.out_on == '0)
        else $error("outputs on with ground lost");
    fail_safe_off_a: assert property (held(sense.fail_safe) |-> drive.out_on == '0)
        else $error("outputs on during fail-safe");
    thermal_out_off_a: assert property (held(sense.temp_one) |-> drive.out_on == '0)
        else $error("outputs on during thermal shutdown");
    thermal_pump_off_a: assert property (held(sense.temp_one) |-> !drive.pump_en)
        else $error("pump runs after thermal shutdown");
    battery_pump_off_a: assert property (held(sense.bat_ov) |-> !drive.pump_en)
        else $error("pump runs on battery overvoltage");
    overcurrent_off_a: assert property (held(sense.overcurrent[4]) |-> !drive.out_on[4])
        else $error("driver on during overcurrent");
    pump_gates_hs_a: assert property ((!drive.pump_en && !$past(drive.pump_en)) |-> drive.out_on[11:4] == '0)
        else $error("high side on without pump");
endmodule : prot_checker

bind output_protection_control prot_checker u_prot_chk (.aclk, .aresetn, .sense, .drive);

// file: testbench/axi_host_model.sv
// Microcontroller side: AXI4-Lite master doing single register reads and writes.
// Assumes the slave answers in its own time; the bench watchdog bounds every wait.
`timescale 1ns/1ps
module axi_host_model (
    input wire logic aclk,
    output logic [31:0] s_axi_awaddr = '0,
    output logic s_axi_awvalid = 1'b0,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata = '0,
    output logic [3:0] s_axi_wstrb = 4'hf,
    output logic s_axi_wvalid = 1'b0,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready = 1'b0,
    output logic [31:0] s_axi_araddr = '0,
    output logic s_axi_arvalid = 1'b0,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready = 1'b0
);
    task automatic write_reg(input logic [7:0] addr, input logic [31:0] data, output logic [1:0] resp);
        logic aw_left = 1'b1;
        logic w_left = 1'b1;
        logic done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= {24'h0, addr};
        s_axi_wdata <= data;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // Each channel drops its valid only at the edge that took it
        while (aw_left || w_left || !done) begin
            @(posedge aclk);
            if (s_axi_awready) aw_left = 1'b0;
            if (s_axi_wready) w_left = 1'b0;
            if (s_axi_bvalid) begin
                done = 1'b1;
                resp = s_axi_bresp;
            end
            s_axi_awvalid <= aw_left;
            s_axi_wvalid <= w_left;
            s_axi_bready <= !done;
        end
    endtask : write_reg

    task automatic read_reg(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] resp);
        logic ar_left = 1'b1;
        logic done = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= {24'h0, addr};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (ar_left || !done) begin
            @(posedge aclk);
            if (s_axi_arready) ar_left = 1'b0;
            if (s_axi_rvalid) begin
                done = 1'b1;
                data = s_axi_rdata;
                resp = s_axi_rresp;
            end
            s_axi_arvalid <= ar_left;
            s_axi_rready <= !done;
        end
    endtask : read_reg
endmodule : axi_host_model

// file: testbench/output_protection_control_bench.sv
// Self-checking bench for output_protection_control: source select table, then fault scenarios.
// Assumes axi_host_model and prot_checker are compiled before it.
`timescale 1ns/1ps
module output_protection_control_bench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    prot_pkg::sense_t sense = '0;
    prot_pkg::drive_t drive;
    logic bat_power_ok = 1'b1;
    logic regsup_power_ok = 1'b1;
    logic timer_one = 1'b1;
    logic timer_one_restart = 1'b0;
    logic [9:0] pwm_gen = 10'h155;
    int miscompares = 0;
    int cmp_count = 0;
    // Source code in [4:1], expected level of driver 4 in [0]; timer one, dir one, even PWM lines high, others low
    logic [4:0] rows [16] = '{5'h00, 5'h03, 5'h05, 5'h06, 5'h09, 5'h0a, 5'h0d, 5'h0e,
                              5'h11, 5'h12, 5'h15, 5'h16, 5'h19, 5'h1a, 5'h1d, 5'h1e};
    always #5 aclk = ~aclk;
    axi_host_model u_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    output_protection_control u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .sense, .bat_power_ok, .regsup_power_ok, .timer_one, .timer_two(1'b0),
        .timer_one_restart, .timer_two_restart(1'b0), .pwm_gen, .direction_input_one(1'b1),
        .direction_input_two(1'b0), .out_request(14'h0), .drive);

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic rd(input logic [7:0] addr, input logic [31:0] mask, input logic [31:0] exp,
                      input logic [1:0] er = 2'b00);
        logic [31:0] data;
        logic [1:0] resp;
        u_host.read_reg(addr, data, resp);
        check({resp, data[29:0] & mask[29:0]}, {er, exp[29:0]});
    endtask : rd

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        logic [1:0] resp;
        u_host.write_reg(addr, data, resp);
    endtask : wr

    // Covers synchronizer and output register with margin
    task automatic settle();
        repeat (20) @(posedge aclk);
    endtask : settle

    task automatic test_done();
        $display("compares=%0d miscompares=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (6000) @(posedge aclk);
        miscompares++;
        test_done();
    end

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(prot_pkg::a_ctrl, 32'hf, prot_pkg::ctrl_rst);
        rd(8'h40, 32'hffff_ffff, 32'h0, 2'b10);
        for (int i = 0; i < 16; i++) begin
            wr(prot_pkg::a_src0, {28'h0, rows[i][4:1]});
            settle();
            check(drive.out_on[4], rows[i][0]);
        end
        timer_one <= 1'b0;
        wr(prot_pkg::a_src0, 32'h2);
        settle();
        check(drive.out_on[4], 0);
        timer_one_restart <= 1'b1;
        @(posedge aclk);
        timer_one_restart <= 1'b0;
        @(posedge aclk);
        // Restart pulse shows as a single ON cycle two edges later
        #1;
        check(drive.out_on[4], 1);
        wr(prot_pkg::a_src0, 32'h1);
        wr(prot_pkg::a_src1, 32'h10);
        settle();
        check(drive.contact_on, 1);
        sense.regsup_ov <= 1'b1;
        settle();
        check({drive.contact_on, drive.lin_hiz}, 2'b01);
        sense.regsup_ov <= 1'b0;
        settle();
        check(drive.contact_on, 1);
        rd(prot_pkg::a_supst, 32'h1, 32'h0);
        wr(prot_pkg::a_ctrl, 32'h2);
        sense.regsup_ov <= 1'b1;
        settle();
        check(drive.contact_on, 1);
        rd(prot_pkg::a_supst, 32'h1, 32'h1);
        sense.regsup_ov <= 1'b0;
        wr(prot_pkg::a_ctrl, 32'h7);
        sense.regsup_uv <= 1'b1;
        settle();
        check({drive.contact_on, drive.lin_hiz}, 2'b01);
        sense.regsup_uv <= 1'b0;
        settle();
        check(drive.contact_on, 0);
        rd(prot_pkg::a_supst, 32'h2, 32'h2);
        settle();
        check(drive.contact_on, 1);
        sense.overcurrent[4] <= 1'b1;
        settle();
        check(drive.out_on[4], 0);
        sense.overcurrent[4] <= 1'b0;
        settle();
        check(drive.out_on[4], 0);
        rd(prot_pkg::a_ocst, 32'h10, 32'h10);
        settle();
        check(drive.out_on[4], 1);
        sense.open_load[4] <= 1'b1;
        settle();
        check(drive.out_on[4], 1);
        sense.open_load[4] <= 1'b0;
        settle();
        rd(prot_pkg::a_olst, 32'h10, 32'h10);
        rd(prot_pkg::a_olst, 32'h10, 32'h0);
        wr(prot_pkg::a_ctrl, 32'hf);
        settle();
        check({drive.pump_en, drive.out_on[4], drive.contact_on}, 3'b001);
        wr(prot_pkg::a_ctrl, 32'h7);
        wr(prot_pkg::a_tim, 32'h0010_1000);
        for (int live = 0; live < 2; live++) begin
            sense.pump_low <= 1'b1;
            repeat (40) @(posedge aclk);
            check({drive.out_on[4], drive.gate_rl, drive.ec_off}, 3'b011);
            sense.pump_low <= 1'b0;
            settle();
            check(drive.out_on[4], live);
            if (live == 0) rd(prot_pkg::a_supst, 32'h8, 32'h8);
            settle();
            check(drive.out_on[4], 1);
            wr(prot_pkg::a_cfg, 32'h1);
        end
        sense.gnd_lost <= 1'b1;
        settle();
        check(drive.out_on, 14'h0);
        sense.gnd_lost <= 1'b0;
        settle();
        check(drive.out_on[4], 0);
        bat_power_ok <= 1'b0;
        regsup_power_ok <= 1'b0;
        settle();
        bat_power_ok <= 1'b1;
        regsup_power_ok <= 1'b1;
        settle();
        check(drive.out_on[4], 1);
        sense.temp_one <= 1'b1;
        sense.fail_safe <= 1'b1;
        sense.bat_ov <= 1'b1;
        settle();
        check({drive.pump_en, drive.out_on}, 15'h0);
        test_done();
    end
endmodule : output_protection_control_bench
